// File: hdl/csma_pkg.sv
`default_nettype none
package csma_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned BUS_TIMEOUT_MS  = 100;
    localparam int unsigned BUS_TIMEOUT_CYC = (BUS_TIMEOUT_MS * (CLK_HZ / 1000) < 1) ? 1 :
                                              BUS_TIMEOUT_MS * (CLK_HZ / 1000);

    // AXI4-Lite layout
    localparam int unsigned AXI_AW = 8;
    localparam int unsigned AXI_DW = 32;
    localparam logic [AXI_AW-1:0] REG_AUTO_EN   = 8'h00;
    localparam logic [AXI_AW-1:0] REG_LOC1_EN   = 8'h04;
    localparam logic [AXI_AW-1:0] REG_LOC2_EN   = 8'h08;
    localparam logic [AXI_AW-1:0] REG_MF_CFG    = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_STATUS    = 8'h10;
    localparam logic [1:0]        RESP_OKAY     = 2'h0;
    localparam logic [1:0]        RESP_SLVERR   = 2'h2;

    // Cyclic telegram: auto request bit of byte 0
    localparam int unsigned TG_AUTO_BIT = 5;

    // Per-mode enable set, one byte
    typedef struct packed {
        logic stop_acyc;
        logic start_acyc;
        logic stop_panel;
        logic start_panel;
        logic stop_di;
        logic start_di;
        logic stop_cyc;
        logic start_cyc;
    } csma_en_t;

    localparam csma_en_t AUTO_EN_RST = 8'hAB;
    localparam csma_en_t LOC1_EN_RST = 8'hBE;
    localparam csma_en_t LOC2_EN_RST = 8'hBE;

    // One bit per command source
    typedef struct packed {
        logic acyc;
        logic panel;
        logic di;
        logic cyc;
    } csma_src_t;

    // Multifunction input function codes, two bits per input
    localparam int unsigned MF_NUM       = 3;
    localparam int unsigned MF_CODE_W    = 2;
    localparam logic [1:0]  MF_NONE      = 2'h0;
    localparam logic [1:0]  MF_FORCE_L2  = 2'h1;
    localparam logic [1:0]  MF_TEST      = 2'h2;
    localparam logic [1:0]  MF_STOP      = 2'h3;
    localparam logic [5:0]  MF_CFG_RST   = 6'h00;

    // Status encoding of the active mode
    localparam logic [1:0] STAT_MODE_AUTO = 2'h0;
    localparam logic [1:0] STAT_MODE_LOC1 = 2'h1;
    localparam logic [1:0] STAT_MODE_LOC2 = 2'h2;
    localparam int unsigned STAT_SIM_BIT   = 2;
    localparam int unsigned STAT_BUSF_BIT  = 3;
    localparam int unsigned STAT_LOCAL_BIT = 4;
    localparam int unsigned STAT_STOPI_BIT = 5;

    typedef enum logic [1:0] {
        CSMA_AUTO,
        CSMA_LOC1,
        CSMA_LOC2
    } csma_mode_t;

endpackage : csma_pkg
`default_nettype wire

// File: hdl/csma_edge.sv
`default_nettype none
module csma_edge #(
    parameter int unsigned W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] prev_r;

    // Reset to high so a level already active at reset is not taken as a command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= {W{1'b1}};
        end else begin
            prev_r <= level;
        end
    end

    assign rise = level & ~prev_r;
endmodule : csma_edge
`default_nettype wire

// File: hdl/csma_arbiter.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module csma_arbiter
    import csma_pkg::*;
#(
    parameter int unsigned BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_CYC
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite slave
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [AXI_DW-1:0]   s_axi_wdata,
    input  wire logic [AXI_DW/8-1:0] s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [AXI_DW-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Cyclic fieldbus telegram from the process controller
    input  wire logic                tg_valid,
    input  wire logic [7:0]          tg_byte0,
    input  wire logic                bus_cyc_start,
    input  wire logic                bus_cyc_stop,
    input  wire logic                bus_link_down,
    // Acyclic service tool
    input  wire logic                bus_acyc_start,
    input  wire logic                bus_acyc_stop,
    // Front panel source
    input  wire logic                panel_start,
    input  wire logic                panel_stop,
    input  wire logic                panel_menu_active,
    // Digital inputs
    input  wire logic                forward_start_input,
    input  wire logic                di_stop_input,
    input  wire logic                multifunction_input_zero,
    input  wire logic                multifunction_input_one,
    input  wire logic                multifunction_input_two,
    // To the starter function
    output logic                     start_pulse,
    output logic                     stop_pulse,
    output csma_mode_t               mode,
    output logic                     bus_fault,
    output logic                     local_active,
    output logic                     sim_mode
);

    csma_en_t              auto_en_r;
    csma_en_t              loc1_en_r;
    csma_en_t              loc2_en_r;
    logic [5:0]            mf_cfg_r;
    csma_mode_t            mode_r;
    csma_mode_t            mode_nxt;
    logic                  auto_bit_r;
    logic                  bus_fault_r;
    logic [31:0]           wd_cnt_r;
    logic                  start_r;
    logic                  stop_r;
    logic                  sim_r;
    logic                  local_r;

    logic                  force_l2;
    logic                  mf_test;
    logic                  mf_stop;
    logic [MF_NUM-1:0]     mf_in;
    csma_en_t              en_act;
    csma_src_t             start_lvl;
    csma_src_t             stop_lvl;
    csma_src_t             start_edge;
    csma_src_t             stop_edge;
    logic                  mf_stop_edge;

    // AXI state
    logic                  aw_hold_r;
    logic [AXI_AW-1:0]     awaddr_r;
    logic                  w_hold_r;
    logic [AXI_DW-1:0]     wdata_r;
    logic                  wstrb0_r;
    logic                  bvalid_r;
    logic [1:0]            bresp_r;
    logic                  rvalid_r;
    logic [AXI_DW-1:0]     rdata_r;
    logic [1:0]            rresp_r;
    logic                  wr_do;
    logic                  wr_hit;
    logic [AXI_DW-1:0]     rd_word;
    logic                  rd_hit;
    logic [1:0]            mode_code;
    logic [AXI_DW-1:0]     status_word;

    // Bus slave: address and data are held independently, the write lands once both are in
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready  = !w_hold_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign wr_do = aw_hold_r && w_hold_r && !bvalid_r;

    always_comb begin
        wr_hit = 1'b1;
        unique case (awaddr_r)
            REG_AUTO_EN, REG_LOC1_EN, REG_LOC2_EN, REG_MF_CFG, REG_STATUS : wr_hit = 1'b1;
            default                                                       : wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid && !aw_hold_r) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wdata_r  <= '0;
            wstrb0_r <= 1'b0;
        end else if (s_axi_wvalid && !w_hold_r) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
        end else if (wr_do) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Enable and function settings; only the low byte lane carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_en_r <= AUTO_EN_RST;
            loc1_en_r <= LOC1_EN_RST;
            loc2_en_r <= LOC2_EN_RST;
            mf_cfg_r  <= MF_CFG_RST;
        end else if (wr_do && wstrb0_r) begin
            unique case (awaddr_r)
                REG_AUTO_EN : auto_en_r <= csma_en_t'(wdata_r[7:0]);
                REG_LOC1_EN : loc1_en_r <= csma_en_t'(wdata_r[7:0]);
                REG_LOC2_EN : loc2_en_r <= csma_en_t'(wdata_r[7:0]);
                REG_MF_CFG  : mf_cfg_r  <= wdata_r[5:0];
                default     : ;
            endcase
        end
    end

    always_comb begin
        unique case (mode_r)
            CSMA_AUTO : mode_code = STAT_MODE_AUTO;
            CSMA_LOC1 : mode_code = STAT_MODE_LOC1;
            CSMA_LOC2 : mode_code = STAT_MODE_LOC2;
            default   : mode_code = STAT_MODE_LOC1;
        endcase
    end

    always_comb begin
        status_word                 = '0;
        status_word[1:0]            = mode_code;
        status_word[STAT_SIM_BIT]   = sim_r;
        status_word[STAT_BUSF_BIT]  = bus_fault_r;
        status_word[STAT_LOCAL_BIT] = local_r;
        status_word[STAT_STOPI_BIT] = mf_stop;
    end

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            REG_AUTO_EN : rd_word[7:0] = auto_en_r;
            REG_LOC1_EN : rd_word[7:0] = loc1_en_r;
            REG_LOC2_EN : rd_word[7:0] = loc2_en_r;
            REG_MF_CFG  : rd_word[5:0] = mf_cfg_r;
            REG_STATUS  : rd_word      = status_word;
            default     : rd_hit       = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Sign-of-life watchdog on the cyclic telegram
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_cnt_r    <= '0;
            bus_fault_r <= 1'b1;
        end else if (bus_link_down) begin
            wd_cnt_r    <= '0;
            bus_fault_r <= 1'b1;
        end else if (tg_valid) begin
            wd_cnt_r    <= '0;
            bus_fault_r <= 1'b0;
        end else if (wd_cnt_r >= BUS_TIMEOUT_CYCLES - 1) begin
            bus_fault_r <= 1'b1;
        end else begin
            wd_cnt_r    <= wd_cnt_r + 32'h00000001;
        end
    end

    // Auto request is taken only from a fresh telegram and kept between telegrams
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_bit_r <= 1'b0;
        end else if (tg_valid) begin
            auto_bit_r <= tg_byte0[TG_AUTO_BIT];
        end
    end

    // Multifunction inputs are ORed per function, so the source input does not matter
    assign mf_in = {multifunction_input_two, multifunction_input_one, multifunction_input_zero};

    always_comb begin
        force_l2 = 1'b0;
        mf_test  = 1'b0;
        mf_stop  = 1'b0;
        for (int i = 0; i < MF_NUM; i++) begin
            if (mf_in[i]) begin
                unique case (mf_cfg_r[i*MF_CODE_W +: MF_CODE_W])
                    MF_FORCE_L2 : force_l2 = 1'b1;
                    MF_TEST     : mf_test  = 1'b1;
                    MF_STOP     : mf_stop  = 1'b1;
                    default     : ;
                endcase
            end
        end
    end

    // Panel menu sits below force local 2 so the forced mode keeps overriding
    always_comb begin
        if (bus_fault_r) begin
            mode_nxt = CSMA_LOC1;
        end else if (force_l2) begin
            mode_nxt = CSMA_LOC2;
        end else if (panel_menu_active) begin
            mode_nxt = CSMA_LOC1;
        end else if (auto_bit_r) begin
            mode_nxt = CSMA_AUTO;
        end else begin
            mode_nxt = CSMA_LOC1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= CSMA_LOC1;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_r <= 1'b1;
            sim_r   <= 1'b0;
        end else begin
            local_r <= (mode_nxt != CSMA_AUTO);
            sim_r   <= mf_test;
        end
    end

    // Enable set of the registered mode
    always_comb begin
        unique case (mode_r)
            CSMA_AUTO : en_act = auto_en_r;
            CSMA_LOC2 : en_act = loc2_en_r;
            default   : en_act = loc1_en_r;
        endcase
    end

    assign start_lvl = {bus_acyc_start, panel_start, forward_start_input, bus_cyc_start};
    assign stop_lvl  = '{acyc: bus_acyc_stop, panel: panel_stop, di: di_stop_input, cyc: bus_cyc_stop};

    csma_edge #(
        .W     (9)
    ) u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   ({mf_stop, stop_lvl, start_lvl}),
        .rise    ({mf_stop_edge, stop_edge, start_edge})
    );

    // Stop outranks start in the same cycle; a held multifunction stop input refuses all starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end else begin
            stop_r  <= (stop_edge.cyc   && en_act.stop_cyc)   ||
                       (stop_edge.di    && en_act.stop_di)    ||
                       (stop_edge.panel && en_act.stop_panel) ||
                       (stop_edge.acyc  && en_act.stop_acyc)  ||
                       mf_stop_edge;
            start_r <= ((start_edge.cyc   && en_act.start_cyc)   ||
                        (start_edge.di    && en_act.start_di)    ||
                        (start_edge.panel && en_act.start_panel) ||
                        (start_edge.acyc  && en_act.start_acyc)) &&
                       !mf_stop &&
                       !((stop_edge.cyc   && en_act.stop_cyc)   ||
                         (stop_edge.di    && en_act.stop_di)    ||
                         (stop_edge.panel && en_act.stop_panel) ||
                         (stop_edge.acyc  && en_act.stop_acyc));
        end
    end

    assign start_pulse  = start_r;
    assign stop_pulse   = stop_r;
    assign mode         = mode_r;
    assign bus_fault    = bus_fault_r;
    assign local_active = local_r;
    assign sim_mode     = sim_r;

endmodule : csma_arbiter
`default_nettype wire

// File: test/csma_arbiter_assertions.sv
`default_nettype none
module csma_arbiter_assertions
    import csma_pkg::*;
#(
    parameter int unsigned BUS_TIMEOUT_CYCLES = 16
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        tg_valid,
    input wire logic        bus_link_down,
    input wire logic        panel_menu_active,
    input wire logic        forward_start_input,
    input wire logic        panel_start,
    input wire logic        bus_cyc_start,
    input wire logic        bus_acyc_start,
    input wire logic        start_pulse,
    input wire logic        stop_pulse,
    input var  csma_mode_t  mode,
    input wire logic        bus_fault,
    input wire logic        local_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [3:0]  req_q;
    int unsigned gap;
    wire  [3:0]  req = {bus_acyc_start, panel_start, forward_start_input, bus_cyc_start};

    always_ff @(posedge aclk) begin
        req_q <= req;
    end
    // Capped at 1000, so the check below can only fire for timeouts of up to 998 cycles, not full-size ones
    always_ff @(posedge aclk) begin
        if (!aresetn || tg_valid) gap <= 0;
        else if (gap < 1000) gap <= gap + 1;
    end

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    AST_WR_LAT: assert property (s_wr_take |=> ##1 s_axi_bvalid)
        else $error("write response late");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    AST_RD_LAT: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response late");
    AST_BUSF_MODE: assert property (bus_fault |=> mode == CSMA_LOC1)
        else $error("bus fault did not force first local");
    AST_LINK: assert property (bus_link_down |=> bus_fault)
        else $error("link down without bus fault");
    AST_WD: assert property (gap > BUS_TIMEOUT_CYCLES + 1 |-> bus_fault)
        else $error("silent master without bus fault");
    AST_LOCAL: assert property (local_active == (mode != CSMA_AUTO))
        else $error("local flag disagrees with mode");
    AST_MENU: assert property (panel_menu_active |=> local_active)
        else $error("panel menu did not give local control");
    AST_AUTO: assert property (mode == CSMA_AUTO |-> !$past(bus_fault) && !$past(panel_menu_active))
        else $error("auto mode against priority");
    AST_START_CAUSE: assert property (start_pulse |-> $past(|(req & ~req_q)))
        else $error("start without a request edge");
    AST_EXCL: assert property (!(start_pulse && stop_pulse))
        else $error("start and stop together");
endmodule : csma_arbiter_assertions

bind csma_arbiter csma_arbiter_assertions #(.BUS_TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)) u_csma_arbiter_assertions (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .tg_valid(tg_valid), .bus_link_down(bus_link_down),
    .panel_menu_active(panel_menu_active), .forward_start_input(forward_start_input),
    .panel_start(panel_start), .bus_cyc_start(bus_cyc_start), .bus_acyc_start(bus_acyc_start),
    .start_pulse(start_pulse), .stop_pulse(stop_pulse), .mode(mode), .bus_fault(bus_fault),
    .local_active(local_active)
);
`default_nettype wire

// File: test/csma_bus_master.sv
`default_nettype none
module csma_bus_master (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       live,
    input  wire logic       auto_req,
    output logic            tg_valid,
    output logic [7:0]      tg_byte0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;

    always_ff @(posedge aclk) begin
        cnt_r <= aresetn ? cnt_r + 2'h1 : 2'h0;
    end
    // Telegram every fourth cycle; a silent master is the sign-of-life loss
    always_ff @(posedge aclk) begin
        tg_valid <= aresetn && live && (cnt_r == 2'h3);
    end
    // Between telegrams the byte toggles so stale data is never trusted
    always_ff @(posedge aclk) begin
        if (aresetn && live && (cnt_r == 2'h3)) tg_byte0 <= {2'h0, auto_req, 5'h00};
        else tg_byte0 <= ~tg_byte0;
    end
endmodule : csma_bus_master
`default_nettype wire

// File: test/test_csma_arbiter.sv
`default_nettype none
module test_csma_arbiter;
    import csma_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic        tg_valid, live = 1'b0, auto_req = 1'b0, link_down = 1'b0, menu = 1'b0;
    logic [7:0]  tg_byte0;
    logic [3:0]  st = 4'h0, sp = 4'h0, ns, np;
    logic [2:0]  mf = 3'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        start_pulse, stop_pulse, bus_fault, local_active, sim_mode;
    csma_mode_t  mode;
    int          fails = 0, tests_run = 0;
    csma_en_t    en_tab [3] = '{AUTO_EN_RST, LOC1_EN_RST, LOC2_EN_RST};
    csma_mode_t  md_tab [3] = '{CSMA_AUTO, CSMA_LOC1, CSMA_LOC2};

    always #25 aclk = ~aclk;

    csma_bus_master u_csma_bus_master (.aclk(aclk), .aresetn(aresetn), .live(live), .auto_req(auto_req),
        .tg_valid(tg_valid), .tg_byte0(tg_byte0));

    csma_arbiter #(.BUS_TIMEOUT_CYCLES(16)) u_csma_arbiter (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tg_valid(tg_valid),
        .tg_byte0(tg_byte0), .bus_cyc_start(st[0]), .bus_cyc_stop(sp[0]), .bus_link_down(link_down),
        .bus_acyc_start(st[3]), .bus_acyc_stop(sp[3]), .panel_start(st[2]), .panel_stop(sp[2]),
        .panel_menu_active(menu), .forward_start_input(st[1]), .di_stop_input(sp[1]),
        .multifunction_input_zero(mf[0]), .multifunction_input_one(mf[1]),
        .multifunction_input_two(mf[2]), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
        .mode(mode), .bus_fault(bus_fault), .local_active(local_active), .sim_mode(sim_mode));

    task automatic print_verdict();
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // Sampling on the falling edge sees exactly what the next rising edge will see
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r  = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        // Let an edge pass so a following call does not raise bready in the same step
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // Holds the levels four cycles, so a second pulse would show a level-sensitive start
    task automatic fire(input logic [3:0] s, input logic [3:0] p, output logic [3:0] cs, output logic [3:0] cp);
        cs = 4'h0;
        cp = 4'h0;
        st <= s;
        sp <= p;
        repeat (4) begin
            @(negedge aclk);
            cs += start_pulse;
            cp += stop_pulse;
            @(posedge aclk);
        end
        st <= 4'h0;
        sp <= 4'h0;
        repeat (2) @(posedge aclk);
    endtask : fire

    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(mode, CSMA_LOC1);
        check(bus_fault, 1'b1);
        @(posedge aclk);
        axi_rd(REG_AUTO_EN, rd, resp);
        check(rd, AUTO_EN_RST);
        axi_rd(REG_LOC1_EN, rd, resp);
        check(rd, LOC1_EN_RST);
        axi_rd(REG_LOC2_EN, rd, resp);
        check(rd, LOC2_EN_RST);
        axi_rd(8'h14, rd, resp);
        check(resp, RESP_SLVERR);
        axi_wr(REG_MF_CFG, 32'h39, resp);
        check(resp, RESP_OKAY);
        live <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            auto_req <= (m != 1);
            mf[0]    <= (m == 2);
            repeat (12) @(posedge aclk);
            check(mode, md_tab[m]);
            check(bus_fault, 1'b0);
            for (int i = 0; i < 4; i++) begin
                fire(4'h1 << i, 4'h0, ns, np);
                check(ns, en_tab[m][2*i]);
                fire(4'h0, 4'h1 << i, ns, np);
                check(np, en_tab[m][2*i+1]);
            end
        end
        fire(4'h2, 4'h2, ns, np);
        check({ns, np}, 8'h01);
        fire(4'h6, 4'h0, ns, np);
        check(ns, 4'h1);
        mf[2] <= 1'b1;
        repeat (2) @(posedge aclk);
        fire(4'h6, 4'h0, ns, np);
        check(ns, 4'h0);
        axi_rd(REG_STATUS, rd, resp);
        check(rd, 32'h32);
        mf[2] <= 1'b0;
        mf[1] <= 1'b1;
        repeat (3) @(posedge aclk);
        check(sim_mode, 1'b1);
        mf[1] <= 1'b0;
        mf[0] <= 1'b0;
        menu  <= 1'b1;
        repeat (3) @(posedge aclk);
        check(mode, CSMA_LOC1);
        check(local_active, 1'b1);
        menu <= 1'b0;
        axi_wr(REG_AUTO_EN, 32'h04, resp);
        axi_wr(8'h14, 32'hFF, resp);
        check(resp, RESP_SLVERR);
        wstrb <= 4'h0;
        axi_wr(REG_AUTO_EN, 32'hFF, resp);
        check(resp, RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(REG_AUTO_EN, rd, resp);
        check(rd, 32'h04);
        repeat (3) @(posedge aclk);
        check(mode, CSMA_AUTO);
        fire(4'h2, 4'h1, ns, np);
        check({ns, np}, 8'h10);
        mf[0] <= 1'b1;
        live  <= 1'b0;
        repeat (30) @(posedge aclk);
        check(bus_fault, 1'b1);
        check(mode, CSMA_LOC1);
        link_down <= 1'b1;
        live      <= 1'b1;
        repeat (12) @(posedge aclk);
        check(bus_fault, 1'b1);
        print_verdict();
    end
endmodule : test_csma_arbiter
`default_nettype wire
